/* File: pobs_pkg.sv */
// package for the power-on boot sequencer: timing constants and states
// assumes a single 40 MHz system controller clock
package pobs_pkg;
  localparam int CLK_PERIOD_PS = 25000;
  localparam int BOOT_DELAY_NS = 10000;
  localparam int BANK_OUT_DELAY_NS = 200;
  localparam int BOOT_DELAY_CYC = (BOOT_DELAY_NS * 1000) / CLK_PERIOD_PS;
  localparam int BANK_OUT_DELAY_CYC = (BANK_OUT_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DLY_W = 16;
  typedef enum logic [3:0] {
    ST_POR, ST_WAIT, ST_NVS_PWR, ST_NVS_EN, ST_XCVR_IO, ST_USR_DET,
    ST_FAB_PWR, ST_FAB_EN, ST_BANK_CFG, ST_DONE
  } pobs_state_t;
endpackage

/* File: pobs_delay.sv */
// cycle counter that raises done after a fixed count while start holds
// assumes start is a level; dropping it restarts the count
`timescale 1ns/1ps
`default_nettype none
module pobs_delay #(
  parameter int COUNT = 4,
  parameter int W = 16
) (
  input wire logic clock, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic start, // level, count while high
  output logic done // high once count reached
);
  logic [W-1:0] cnt;
  // count up while start holds, saturate at COUNT
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (!start) begin
      cnt <= '0;
    end else if (cnt != W'(COUNT)) begin
      cnt <= cnt + 1'b1;
    end
  end
  assign done = start && (cnt == W'(COUNT));
endmodule
`default_nettype wire

/* File: power_on_boot_sequencer.sv */
// power-on boot sequencer: holds controller in reset, then runs boot steps
// assumes detector inputs are synchronous to clock; outputs enable blocks
// What this block does
// R1: controller reset while any core rail low
// R2: wait 10 us after rails good
// R3: bank supplies watched by separate detectors
// R4: during reset, fabric/transceivers off, banks tri-stated
// R5: bank 3 inputs, outputs 200 ns later
// R6: fixed boot sequence, design independent
// R7: power up and enable nonvolatile store
// R8: enable transceiver IO pins
// R9: enable user voltage detectors
// R10: power up fabric, then enable it
// R11: configure high-speed and general banks
// R12: high-speed banks unusable before calibration
// R13: processor subsystem down, its pins tri-stated
// R14: steps in order, then hold boot done
// R15: rail drop returns to power-on reset
`timescale 1ns/1ps
`default_nettype none
module power_on_boot_sequencer
  import pobs_pkg::*;
#(
  parameter int BOOT_CYC = BOOT_DELAY_CYC,
  parameter int BANK_CYC = BANK_OUT_DELAY_CYC
) (
  input wire logic clock, // 40 MHz system clock
  input wire logic rst_n, // power-on reset, active low
  input wire logic coreOk, // core rail above threshold
  input wire logic aux1v8RailOk, // aux_1v8_rail above threshold
  input wire logic aux2v5RailOk, // aux_2v5_rail above threshold
  input wire logic dedicatedBankIoRailOk, // bank 3 supply detector
  input wire logic ioCalibDone, // io calibration complete
  output logic sysCtrlReset, // system controller held in reset
  output logic dedicatedBankInEn, // bank 3 input enable
  output logic dedicatedBankOutEn, // bank 3 output enable
  output logic nvStorePwr, // secure_nonvolatile_store power
  output logic nvStoreEn, // secure_nonvolatile_store enable
  output logic xcvrIoEn, // transceiver pin enable
  output logic xcvrPwr, // transceiver power
  output logic userDetEn, // user voltage detector enable
  output logic fabricPwr, // fabric power
  output logic fabricEn, // fabric enable
  output logic bankCfgDone, // high-speed and general banks configured
  output logic bankTriState, // high-speed and general banks tri-stated
  output logic generalBankUsable, // general banks usable
  output logic highSpeedBankUsable, // high_speed_io_bank usable
  output logic procSubsysPwr, // processor_subsystem power
  output logic procSubsysPinsTriState, // processor_subsystem_pins tri-stated
  output logic bootDone // boot complete, held
);
  pobs_state_t state;
  pobs_state_t next_state;
  logic railsOk;
  logic bootDlyDone;
  logic bankDlyDone;

  // all monitored core rails good
  assign railsOk = coreOk && aux1v8RailOk && aux2v5RailOk; // R1

  // fixed boot start delay after rails come good
  pobs_delay #(.COUNT(BOOT_CYC), .W(DLY_W)) uBootDly (
    .clock(clock),
    .rst_n(rst_n),
    .start(state == ST_WAIT), // R2
    .done(bootDlyDone)
  );

  // bank 3 output delay from its own detector
  pobs_delay #(.COUNT(BANK_CYC), .W(DLY_W)) uBankDly (
    .clock(clock),
    .rst_n(rst_n),
    .start(dedicatedBankIoRailOk), // R3
    .done(bankDlyDone)
  );

  // fixed step order, same for every design
  always_comb begin
    next_state = state;
    case (state)
      ST_POR: if (railsOk) next_state = ST_WAIT;
      ST_WAIT: if (bootDlyDone) next_state = ST_NVS_PWR; // R2
      ST_NVS_PWR: next_state = ST_NVS_EN; // R7
      ST_NVS_EN: next_state = ST_XCVR_IO; // R8
      ST_XCVR_IO: next_state = ST_USR_DET; // R9
      ST_USR_DET: next_state = ST_FAB_PWR; // R10
      ST_FAB_PWR: next_state = ST_FAB_EN; // R10
      ST_FAB_EN: next_state = ST_BANK_CFG; // R11
      ST_BANK_CFG: next_state = ST_DONE; // R14
      ST_DONE: next_state = ST_DONE;
      default: next_state = ST_POR;
    endcase
    if (!railsOk) begin
      next_state = ST_POR; // R15
    end
  end

  // state register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_POR;
    end else begin
      state <= next_state; // R6
    end
  end

  // controller reset and step outputs, each set once its step is reached
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sysCtrlReset <= 1'b1;
      nvStorePwr <= 1'b0;
      nvStoreEn <= 1'b0;
      xcvrIoEn <= 1'b0;
      xcvrPwr <= 1'b0;
      userDetEn <= 1'b0;
      fabricPwr <= 1'b0;
      fabricEn <= 1'b0;
      bankCfgDone <= 1'b0;
      bankTriState <= 1'b1;
      bootDone <= 1'b0;
    end else if (next_state == ST_POR) begin
      sysCtrlReset <= 1'b1; // R1
      nvStorePwr <= 1'b0; // R4
      nvStoreEn <= 1'b0;
      xcvrIoEn <= 1'b0;
      xcvrPwr <= 1'b0; // R4
      userDetEn <= 1'b0;
      fabricPwr <= 1'b0; // R4
      fabricEn <= 1'b0;
      bankCfgDone <= 1'b0;
      bankTriState <= 1'b1; // R4
      bootDone <= 1'b0;
    end else begin
      sysCtrlReset <= 1'b0;
      if (next_state == ST_NVS_PWR) nvStorePwr <= 1'b1; // R7
      if (next_state == ST_NVS_EN) nvStoreEn <= 1'b1; // R7
      if (next_state == ST_XCVR_IO) begin
        xcvrPwr <= 1'b1;
        xcvrIoEn <= 1'b1; // R8
      end
      if (next_state == ST_USR_DET) userDetEn <= 1'b1; // R9
      if (next_state == ST_FAB_PWR) fabricPwr <= 1'b1; // R10
      if (next_state == ST_FAB_EN) fabricEn <= 1'b1; // R10
      if (next_state == ST_BANK_CFG) begin
        bankCfgDone <= 1'b1; // R11
        bankTriState <= 1'b0;
      end
      if (next_state == ST_DONE) bootDone <= 1'b1; // R14
    end
  end

  // bank 3 enables track its own supply, outputs after the delay
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dedicatedBankInEn <= 1'b0;
      dedicatedBankOutEn <= 1'b0;
    end else begin
      dedicatedBankInEn <= dedicatedBankIoRailOk; // R5
      dedicatedBankOutEn <= bankDlyDone; // R5
    end
  end

  // bank usability; high-speed waits for calibration
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      generalBankUsable <= 1'b0;
      highSpeedBankUsable <= 1'b0;
    end else begin
      generalBankUsable <= bankCfgDone && railsOk;
      highSpeedBankUsable <= bankCfgDone && railsOk && ioCalibDone; // R12
    end
  end

  // processor subsystem stays down through boot
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      procSubsysPwr <= 1'b0;
      procSubsysPinsTriState <= 1'b1;
    end else begin
      procSubsysPwr <= 1'b0; // R13
      procSubsysPinsTriState <= 1'b1; // R13
    end
  end

  // checks
  a_reset_rails: assert property (@(posedge clock) disable iff (!rst_n)
    !railsOk |=> sysCtrlReset && !fabricPwr && bankTriState) // R1
    else $error("controller not held in reset with rail low");
  a_boot_delay: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(railsOk) |-> !nvStorePwr [*8]) // R2
    else $error("boot began before delay");
  a_xcvr_off: assert property (@(posedge clock) disable iff (!rst_n)
    sysCtrlReset |-> !xcvrPwr && !fabricEn) // R4
    else $error("blocks up during reset");
  a_bank_out: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(dedicatedBankIoRailOk) |=> !dedicatedBankOutEn [*7]) // R5
    else $error("bank 3 outputs too early");
  a_bank_in: assert property (@(posedge clock) disable iff (!rst_n)
    dedicatedBankOutEn |-> dedicatedBankInEn) // R5
    else $error("bank 3 outputs without inputs");
  a_nvs_order: assert property (@(posedge clock) disable iff (!rst_n)
    nvStoreEn |-> nvStorePwr) // R7
    else $error("store enabled unpowered");
  a_fab_order: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(fabricPwr) |-> !fabricEn ##1 (fabricEn || !railsOk)) // R10
    else $error("fabric step order wrong");
  a_hs_calib: assert property (@(posedge clock) disable iff (!rst_n)
    highSpeedBankUsable |-> $past(ioCalibDone)) // R12
    else $error("high-speed bank usable before calibration");
  a_proc_down: assert property (@(posedge clock) disable iff (!rst_n)
    !procSubsysPwr && procSubsysPinsTriState) // R13
    else $error("processor subsystem not held down");
  a_done_hold: assert property (@(posedge clock) disable iff (!rst_n)
    bootDone && railsOk |=> bootDone) // R14
    else $error("boot done dropped");
  a_done_all: assert property (@(posedge clock) disable iff (!rst_n)
    bootDone |-> nvStoreEn && xcvrIoEn && userDetEn && fabricEn && bankCfgDone) // R14
    else $error("boot done before all steps");
  c_boot: cover property (@(posedge clock) disable iff (!rst_n) $rose(bootDone));
  c_drop: cover property (@(posedge clock) disable iff (!rst_n) bootDone ##1 sysCtrlReset);
  c_bank: cover property (@(posedge clock) disable iff (!rst_n) $rose(dedicatedBankOutEn));
  c_hs: cover property (@(posedge clock) disable iff (!rst_n) $rose(highSpeedBankUsable));
endmodule
`default_nettype wire

/* File: pobs_supply_model.sv */
// supply detector model: one detector output per requested supply level
// assumes the bench sets the requested levels just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module pobs_supply_model (
  input wire logic [2:0] coreSup, // requested core, 1v8, 2v5 levels
  input wire logic bankSup, // requested bank 3 level
  input wire logic calibSup, // calibration finished
  output logic coreOk, // core detector
  output logic aux1v8RailOk, // aux_1v8_rail detector
  output logic aux2v5RailOk, // aux_2v5_rail detector
  output logic dedicatedBankIoRailOk, // bank 3 detector
  output logic ioCalibDone // calibration status
);
  // core rail detectors follow their own supply only
  assign coreOk = coreSup[0];
  assign aux1v8RailOk = coreSup[1];
  assign aux2v5RailOk = coreSup[2];
  // bank 3 detector is separate from the core rail detectors
  assign dedicatedBankIoRailOk = bankSup;
  assign ioCalibDone = calibSup;
endmodule
`default_nettype wire

/* File: testbench.sv */
// bench for the power-on boot sequencer with a shortened boot delay
// assumes 40 MHz clock; supplies come from the detector model
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pobs_pkg::*;
  localparam int BOOT = 10;
  localparam int BANK = 8;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] coreSup = 3'h0;
  logic bankSup = 1'b0;
  logic calibSup = 1'b0;
  logic coreOk, aux1v8RailOk, aux2v5RailOk, dedicatedBankIoRailOk, ioCalibDone;
  logic sysCtrlReset, dedicatedBankInEn, dedicatedBankOutEn, nvStorePwr, nvStoreEn;
  logic xcvrIoEn, xcvrPwr, userDetEn, fabricPwr, fabricEn, bankCfgDone, bankTriState;
  logic generalBankUsable, highSpeedBankUsable, procSubsysPwr, procSubsysPinsTriState;
  logic bootDone;
  logic [7:0] steps;
  logic [7:0] prev;
  int fails = 0;
  int samples_checked = 0;
  int n;
  // boot steps in their expected order, first step in the top bit
  assign steps = {nvStorePwr, nvStoreEn, xcvrIoEn, userDetEn, fabricPwr, fabricEn,
    bankCfgDone, bootDone};
  pobs_supply_model model (.coreSup(coreSup), .bankSup(bankSup), .calibSup(calibSup),
    .coreOk(coreOk), .aux1v8RailOk(aux1v8RailOk), .aux2v5RailOk(aux2v5RailOk),
    .dedicatedBankIoRailOk(dedicatedBankIoRailOk), .ioCalibDone(ioCalibDone));
  power_on_boot_sequencer #(.BOOT_CYC(BOOT), .BANK_CYC(BANK)) dut (.clock(clock),
    .rst_n(rst_n), .coreOk(coreOk), .aux1v8RailOk(aux1v8RailOk),
    .aux2v5RailOk(aux2v5RailOk), .dedicatedBankIoRailOk(dedicatedBankIoRailOk),
    .ioCalibDone(ioCalibDone), .sysCtrlReset(sysCtrlReset),
    .dedicatedBankInEn(dedicatedBankInEn), .dedicatedBankOutEn(dedicatedBankOutEn),
    .nvStorePwr(nvStorePwr), .nvStoreEn(nvStoreEn), .xcvrIoEn(xcvrIoEn),
    .xcvrPwr(xcvrPwr), .userDetEn(userDetEn), .fabricPwr(fabricPwr),
    .fabricEn(fabricEn), .bankCfgDone(bankCfgDone), .bankTriState(bankTriState),
    .generalBankUsable(generalBankUsable), .highSpeedBankUsable(highSpeedBankUsable),
    .procSubsysPwr(procSubsysPwr), .procSubsysPinsTriState(procSubsysPinsTriState),
    .bootDone(bootDone));
  // free running clock, 25 ns period
  initial begin
    forever #12.5 clock = ~clock;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // advance k edges, then settle
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic chk_por();
    check("por held", {sysCtrlReset, bankTriState, procSubsysPinsTriState}, 8'h07);
    check("por steps", steps, 8'h00);
    check("por power", {xcvrPwr, procSubsysPwr, generalBankUsable, highSpeedBankUsable},
      8'h00);
  endtask
  task automatic test_bank();
    bankSup = 1'b1;
    tick(1);
    check("bank in", {dedicatedBankInEn, dedicatedBankOutEn}, 8'h02);
    tick(BANK - 1);
    check("bank out early", dedicatedBankOutEn, 8'h00);
    tick(1);
    check("bank out", dedicatedBankOutEn, 8'h01);
    chk_por();
    $display("test bank done");
  endtask
  task automatic test_rails_missing();
    for (int i = 0; i < 3; i++) begin
      coreSup = 3'h7 & ~(3'h1 << i);
      tick(BOOT + 20);
      chk_por();
      check("bank kept", {dedicatedBankInEn, dedicatedBankOutEn}, 8'h03);
    end
    $display("test rails missing done");
  endtask
  task automatic test_boot();
    coreSup = 3'h7;
    check("reset before edge", sysCtrlReset, 8'h01);
    tick(1);
    check("reset released", sysCtrlReset, 8'h00);
    n = 1;
    while (nvStorePwr !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    check("boot delay", 8'(n), 8'(BOOT + 2));
    for (int k = 0; k < 7; k++) begin
      prev = steps;
      tick(1);
      check("step order", (steps << 1) & ~steps, 8'h00);
      check("one step", 8'($countones(steps)), 8'($countones(prev) + 1));
    end
    check("all steps", steps, 8'hff);
    check("banks", {xcvrPwr, bankTriState, generalBankUsable}, 8'h05);
    check("hs unusable", highSpeedBankUsable, 8'h00);
    check("proc down", {procSubsysPwr, procSubsysPinsTriState}, 8'h01);
    tick(20);
    check("held", steps, 8'hff);
    calibSup = 1'b1;
    tick(2);
    check("hs usable", highSpeedBankUsable, 8'h01);
    $display("test boot done");
  endtask
  task automatic test_drop();
    coreSup = 3'h5;
    tick(1);
    chk_por();
    check("bank kept", {dedicatedBankInEn, dedicatedBankOutEn}, 8'h03);
    bankSup = 1'b0;
    tick(2);
    check("bank off", {dedicatedBankInEn, dedicatedBankOutEn}, 8'h00);
    $display("test drop done");
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // watchdog far beyond the roughly 150 cycles the tests need
  initial begin
    #(25 * 5000);
    fails++;
    $display("watchdog expired");
    conclude();
  end
  // main sequence
  initial begin
    tick(3);
    rst_n = 1'b1;
    chk_por();
    test_bank();
    test_rails_missing();
    test_boot();
    test_drop();
    conclude();
  end
endmodule
`default_nettype wire
